// *** pkg/pdf_defines.svh ***
// Register offsets, field positions and reset values of the debug-fault slice.
// Assumes the including file compiles it once; the guard stops a second pass.
`ifndef PDF_DEFINES_SVH
`define PDF_DEFINES_SVH

// Register offsets on the plain register port
`define PDF_OFS_CTRL 8'h00
`define PDF_OFS_DRV 8'h18
`define PDF_OFS_DBG 8'h1E
`define PDF_OFS_EVT 8'h20
`define PDF_OFS_STAT 8'h2C

// Control register fields
`define PDF_CTRL_SWRST 0
`define PDF_CTRL_ENABLE 1

// Driver control fields
`define PDF_DRV_OVREN_LSB 0
`define PDF_DRV_OVRLVL_LSB 8

// Debug behaviour control fields
`define PDF_DBG_RUN 0
`define PDF_DBG_FAULTEN 2

// Status register fields
`define PDF_STAT_DBGFLAG 0
`define PDF_STAT_HALTED 1
`define PDF_STAT_FAULT 2
`define PDF_STAT_STATE_LSB 4

// Reset values
`define PDF_RST_DRV 32'h0000_0000
`define PDF_RST_DBG 8'h00
`define PDF_RST_EVT 32'h0000_0000

// Synchroniser depth for the debug halt line
`define PDF_SYNC_STAGES 2

`endif

// *** pkg/pdf_pkg.sv ***
// Types shared by the debug-fault slice and its testbench.
// Assumes pdf_defines.svh supplies the numeric constants.
package pdf_pkg;
   typedef logic [7:0] pdf_addr_t;
   typedef logic [31:0] pdf_word_t;
   typedef enum logic [1:0] {PDF_IDLE, PDF_RUNNING, PDF_FROZEN, PDF_FAULTED} pdf_run_t;
endpackage

// *** pkg/pdf_ovr_if.sv ***
// Carrier between the control logic and the waveform output stage.
// Assumes both ends share core_clk and the synchronous reset.
`timescale 1ns/1ns
interface pdf_ovr_if #(parameter int CHANNELS = 8);
   logic clk;
   logic rstN;
   logic ce;
   logic faultActive;
   logic [CHANNELS-1:0] waveIn;
   logic [CHANNELS-1:0] ovrEn;
   logic [CHANNELS-1:0] ovrLevel;
   logic [CHANNELS-1:0] pinOut;
   logic [CHANNELS-1:0] pinOe_n;
   modport ctrl (output clk, rstN, ce, faultActive, waveIn, ovrEn, ovrLevel, input pinOut, pinOe_n);
   modport stage (input clk, rstN, ce, faultActive, waveIn, ovrEn, ovrLevel, output pinOut, pinOe_n);
endinterface

// *** hw/pdf_out_stage.sv ***
// Waveform output stage: applies fault override per channel, registered.
// Assumes the control side drives every interface input from core_clk.
`timescale 1ns/1ns
module pdf_out_stage #(parameter int CHANNELS = 8)
(
   // Control side
   pdf_ovr_if.stage ovr
);
   if (CHANNELS < 1)
   begin : g_badChannels
      $error("CHANNELS must be at least 1");
   end

   logic [CHANNELS-1:0] outNext;
   logic [CHANNELS-1:0] oeNNext;
   logic [CHANNELS-1:0] out_reg;
   logic [CHANNELS-1:0] oeN_reg;

   // Override enable 0 releases the pin, 1 forces the level
   assign outNext = ovr.faultActive ? (ovr.ovrLevel & ovr.ovrEn) : ovr.waveIn;
   assign oeNNext = ovr.faultActive ? ~ovr.ovrEn : '0;

   always_ff @(posedge ovr.clk)
   begin
      if (!ovr.rstN)
      begin
         out_reg <= '0;
         oeN_reg <= '1;
      end
      else if (ovr.ce)
      begin
         out_reg <= outNext;
         oeN_reg <= oeNNext;
      end
   end

   assign ovr.pinOut = out_reg;
   assign ovr.pinOe_n = oeN_reg;

   property p_faultTristate;
      @(posedge ovr.clk) disable iff (!ovr.rstN)
      (ovr.ce && ovr.faultActive) |=> ((~ovr.pinOe_n & ~$past(ovr.ovrEn)) == '0);
   endproperty
   a_faultTristate: assert property (p_faultTristate) else $error("Released channel still driven");

   property p_faultLevel;
      @(posedge ovr.clk) disable iff (!ovr.rstN)
      (ovr.ce && ovr.faultActive) |=>
         (((ovr.pinOut ^ $past(ovr.ovrLevel)) | ovr.pinOe_n) & $past(ovr.ovrEn)) == '0;
   endproperty
   a_faultLevel: assert property (p_faultLevel) else $error("Overridden channel not at level");
endmodule

// *** hw/pdf_debug_fault_ctrl.sv ***
// Debug and non-recoverable fault control slice of a PWM timer.
// Assumes a same-clock timer core and an asynchronous debug halt line.
`timescale 1ns/1ns
`include "pdf_defines.svh"
module pdf_debug_fault_ctrl #(parameter int CHANNELS = 8)
(
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Register port
   input wire pdf_pkg::pdf_addr_t regAddr,
   input wire pdf_pkg::pdf_word_t regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output pdf_pkg::pdf_word_t regRdData,
   // Debug system
   input wire logic haltPin,
   // Timer core
   input wire logic nrFaultIn,
   input wire logic [CHANNELS-1:0] waveIn,
   output logic countEnable,
   output logic faultActive,
   // Waveform pins
   output logic [CHANNELS-1:0] pinOut,
   output logic [CHANNELS-1:0] pinOe_n
);
   if (CHANNELS < 1 || CHANNELS > 8)
   begin : g_badChannels
      $error("CHANNELS must be 1 to 8");
   end

   pdf_ovr_if #(.CHANNELS(CHANNELS)) ovr ();

   // Register state
   pdf_pkg::pdf_word_t drv_reg;
   pdf_pkg::pdf_word_t evt_reg;
   logic [7:0] dbg_reg;
   logic enable_reg;
   logic dbgFlag_reg;
   pdf_pkg::pdf_word_t rdData_reg;
   logic [`PDF_SYNC_STAGES-1:0] haltSync_reg;
   pdf_pkg::pdf_run_t state_reg;
   pdf_pkg::pdf_run_t state_next;

   // Decode
   logic wrCtrl;
   logic wrDrv;
   logic wrDbg;
   logic wrEvt;
   logic wrStat;
   logic swReset;
   logic haltSync;
   logic runWhileHalted;
   logic faultEnable;
   logic debugFault;
   logic flagClear;
   pdf_pkg::pdf_word_t rdMux;

   assign wrCtrl = regWrStrobe && regAddr == `PDF_OFS_CTRL;
   assign wrDrv = regWrStrobe && regAddr == `PDF_OFS_DRV;
   assign wrDbg = regWrStrobe && regAddr == `PDF_OFS_DBG;
   assign wrEvt = regWrStrobe && regAddr == `PDF_OFS_EVT;
   assign wrStat = regWrStrobe && regAddr == `PDF_OFS_STAT;
   assign swReset = wrCtrl && regWrData[`PDF_CTRL_SWRST];

   // Only the second stage is read; the first may be metastable
   assign haltSync = haltSync_reg[`PDF_SYNC_STAGES-1];
   assign runWhileHalted = dbg_reg[`PDF_DBG_RUN];
   assign faultEnable = dbg_reg[`PDF_DBG_FAULTEN];

   assign debugFault = haltSync && faultEnable;
   assign faultActive = nrFaultIn || debugFault;
   assign countEnable = enable_reg && (!haltSync || runWhileHalted);
   assign flagClear = wrStat && regWrData[`PDF_STAT_DBGFLAG];

   assign rdMux =
      (regAddr == `PDF_OFS_CTRL) ? {30'h0000_0000, enable_reg, 1'b0} :
      (regAddr == `PDF_OFS_DRV) ? drv_reg :
      (regAddr == `PDF_OFS_DBG) ? {24'h00_0000, dbg_reg} :
      (regAddr == `PDF_OFS_EVT) ? evt_reg :
      (regAddr == `PDF_OFS_STAT) ?
         {26'h000_0000, state_reg, 1'b0, faultActive, haltSync, dbgFlag_reg} :
      32'h0000_0000;

   // Halt line synchroniser
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         haltSync_reg <= '0;
      else if (clkEn)
         haltSync_reg <= {haltSync_reg[`PDF_SYNC_STAGES-2:0], haltPin};
   end

   // Debug bits: hard reset only, software reset leaves them
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         dbg_reg <= `PDF_RST_DBG;
      else if (clkEn && wrDbg)
         dbg_reg <= regWrData[7:0] & 8'h05;
   end

   // Registers cleared by software reset
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         drv_reg <= `PDF_RST_DRV;
         evt_reg <= `PDF_RST_EVT;
         enable_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         if (swReset)
         begin
            drv_reg <= `PDF_RST_DRV;
            evt_reg <= `PDF_RST_EVT;
            enable_reg <= 1'b0;
         end
         else
         begin
            if (wrDrv)
               drv_reg <= regWrData;
            if (wrEvt)
               evt_reg <= regWrData;
            if (wrCtrl)
               enable_reg <= regWrData[`PDF_CTRL_ENABLE];
         end
      end
   end

   // Sticky flag: a new halt fault beats a same-cycle clear
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         dbgFlag_reg <= 1'b0;
      else if (clkEn)
      begin
         if (debugFault)
            dbgFlag_reg <= 1'b1;
         else if (flagClear || swReset)
            dbgFlag_reg <= 1'b0;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         rdData_reg <= 32'h0000_0000;
      else if (clkEn)
         rdData_reg <= regRdStrobe ? rdMux : 32'h0000_0000;
   end
   assign regRdData = rdData_reg;

   // Run state shown in status
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         pdf_pkg::PDF_IDLE:
            if (enable_reg)
               state_next = pdf_pkg::PDF_RUNNING;
         pdf_pkg::PDF_RUNNING,
         pdf_pkg::PDF_FROZEN,
         pdf_pkg::PDF_FAULTED:
            if (!enable_reg)
               state_next = pdf_pkg::PDF_IDLE;
            else if (faultActive)
               state_next = pdf_pkg::PDF_FAULTED;
            else if (!countEnable)
               state_next = pdf_pkg::PDF_FROZEN;
            else
               state_next = pdf_pkg::PDF_RUNNING;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         state_reg <= pdf_pkg::PDF_IDLE;
      else if (clkEn)
         state_reg <= state_next;
   end

   // Output stage
   assign ovr.clk = core_clk;
   assign ovr.rstN = reset_n;
   assign ovr.ce = clkEn;
   assign ovr.faultActive = faultActive;
   assign ovr.waveIn = waveIn;
   assign ovr.ovrEn = drv_reg[`PDF_DRV_OVREN_LSB +: CHANNELS];
   assign ovr.ovrLevel = drv_reg[`PDF_DRV_OVRLVL_LSB +: CHANNELS];
   assign pinOut = ovr.pinOut;
   assign pinOe_n = ovr.pinOe_n;

   pdf_out_stage #(.CHANNELS(CHANNELS)) u_stage
   (
      .ovr(ovr.stage)
   );

   // Checks
   sequence s_haltHeld;
      clkEn && haltPin ##1 clkEn && haltPin;
   endsequence

   sequence s_haltFault;
      clkEn && haltSync && faultEnable;
   endsequence

   property p_haltSync;
      @(posedge core_clk) disable iff (!reset_n)
      s_haltHeld |=> haltSync;
   endproperty
   a_haltSync: assert property (p_haltSync) else $error("Halt not seen after two edges");

   property p_swResetKeepsDbg;
      @(posedge core_clk) disable iff (!reset_n)
      (clkEn && swReset) |=> (dbg_reg == $past(dbg_reg)) && !enable_reg;
   endproperty
   a_swResetKeepsDbg: assert property (p_swResetKeepsDbg) else $error("Debug bits lost on soft reset");

   property p_breakFault;
      @(posedge core_clk) disable iff (!reset_n)
      s_haltFault |-> faultActive;
   endproperty
   a_breakFault: assert property (p_breakFault) else $error("Break did not raise fault");

   property p_flagSet;
      @(posedge core_clk) disable iff (!reset_n)
      s_haltFault |=> dbgFlag_reg ##1 (dbgFlag_reg || !$past(haltSync) || !$past(faultEnable) || $past(flagClear));
   endproperty
   a_flagSet: assert property (p_flagSet) else $error("Debug fault flag not set");

   property p_noFaultDisabled;
      @(posedge core_clk) disable iff (!reset_n)
      (!faultEnable && !nrFaultIn) |-> !faultActive;
   endproperty
   a_noFaultDisabled: assert property (p_noFaultDisabled) else $error("Fault without enable");

   property p_haltStops;
      @(posedge core_clk) disable iff (!reset_n)
      (haltSync && !runWhileHalted) |-> !countEnable;
   endproperty
   a_haltStops: assert property (p_haltStops) else $error("Counting while halted");

   property p_haltRuns;
      @(posedge core_clk) disable iff (!reset_n)
      (enable_reg && runWhileHalted) |-> countEnable;
   endproperty
   a_haltRuns: assert property (p_haltRuns) else $error("Stopped despite run-while-halted");

   property p_frozenState;
      @(posedge core_clk) disable iff (!reset_n)
      (clkEn && enable_reg && !faultActive && haltSync && !runWhileHalted
         && state_reg != pdf_pkg::PDF_IDLE) |=> state_reg == pdf_pkg::PDF_FROZEN;
   endproperty
   a_frozenState: assert property (p_frozenState) else $error("Frozen state not shown");

   // No disable here: this one watches the reset itself
   property p_hardResetClears;
      @(posedge core_clk)
      !reset_n |=> (dbg_reg == `PDF_RST_DBG) && !dbgFlag_reg && !enable_reg;
   endproperty
   a_hardResetClears: assert property (p_hardResetClears) else $error("Hard reset left state");

   property p_dbgOtherBitsZero;
      @(posedge core_clk) disable iff (!reset_n)
      (dbg_reg & 8'hFA) == 8'h00;
   endproperty
   a_dbgOtherBitsZero: assert property (p_dbgOtherBitsZero) else $error("Unused debug bits set");

   property p_flagClear;
      @(posedge core_clk) disable iff (!reset_n)
      (clkEn && (flagClear || swReset) && !debugFault) |=> !dbgFlag_reg;
   endproperty
   a_flagClear: assert property (p_flagClear) else $error("Debug fault flag not cleared");

   property p_freeze;
      @(posedge core_clk) disable iff (!reset_n)
      !clkEn |=> (dbg_reg == $past(dbg_reg)) && (dbgFlag_reg == $past(dbgFlag_reg))
         && (state_reg == $past(state_reg)) && (regRdData == $past(regRdData));
   endproperty
   a_freeze: assert property (p_freeze) else $error("State moved with clock enable low");

   property p_readIdle;
      @(posedge core_clk) disable iff (!reset_n)
      (clkEn && !regRdStrobe) |=> (regRdData == 32'h0000_0000);
   endproperty
   a_readIdle: assert property (p_readIdle) else $error("Read data outside its cycle");

   property p_readDbg;
      @(posedge core_clk) disable iff (!reset_n)
      (clkEn && regRdStrobe && regAddr == `PDF_OFS_DBG) |=> (regRdData == {24'h00_0000, $past(dbg_reg)});
   endproperty
   a_readDbg: assert property (p_readDbg) else $error("Debug register read wrong");
endmodule

// *** tb/pdf_dbg_model.sv ***
// Debug system model: halt line raised off the clock grid, and pin pads.
// Assumes the bench requests halt on haltReq; pads carry no pull.
`timescale 1ns/1ns
module pdf_dbg_model #(parameter int CHANNELS = 8, parameter int SKEW_NS = 37)
(
   // Bench request
   input wire logic haltReq,
   // Debug halt line
   output logic haltPin,
   // Waveform pins
   input wire logic [CHANNELS-1:0] pinOut,
   input wire logic [CHANNELS-1:0] pinOe_n,
   output wire [CHANNELS-1:0] pad
);
   // Skew keeps the halt edge clear of core_clk, like a real async debugger
   assign #SKEW_NS haltPin = haltReq;
   genvar i;
   for (i = 0; i < CHANNELS; i++)
   begin : g_pad
      assign pad[i] = pinOe_n[i] ? 1'bz : pinOut[i];
   end
endmodule

// *** tb/pwm_timer_debug_fault_ctrl_test.sv ***
// Self-checking bench for the debug-fault slice: registers, halt modes, fault override.
// Assumes pdf_defines.svh on the include path and the design's 2-edge halt lag.
`timescale 1ns/1ns
`include "pdf_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) \
   begin mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module pwm_timer_debug_fault_ctrl_test;
   localparam int CH = 8;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clkEn = 1'b1;
   pdf_pkg::pdf_addr_t regAddr = 8'h00;
   pdf_pkg::pdf_word_t regWrData = 32'h0000_0000;
   logic regWrStrobe = 1'b0;
   logic regRdStrobe = 1'b0;
   pdf_pkg::pdf_word_t regRdData;
   logic haltReq = 1'b0;
   logic haltPin;
   logic nrFaultIn = 1'b0;
   logic [CH-1:0] waveIn = 8'h00;
   logic countEnable;
   logic faultActive;
   logic [CH-1:0] pinOut;
   logic [CH-1:0] pinOe_n;
   wire [CH-1:0] pad;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 80181;
   pdf_pkg::pdf_word_t drv = 32'h0000_0000;
   pdf_pkg::pdf_word_t got;

   always #50 core_clk = ~core_clk;

   pdf_debug_fault_ctrl #(.CHANNELS(CH)) pdf_debug_fault_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
      .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
      .regRdStrobe(regRdStrobe), .regRdData(regRdData), .haltPin(haltPin), .nrFaultIn(nrFaultIn),
      .waveIn(waveIn), .countEnable(countEnable), .faultActive(faultActive), .pinOut(pinOut),
      .pinOe_n(pinOe_n));
   pdf_dbg_model #(.CHANNELS(CH)) pdf_dbg_model_i (.haltReq(haltReq), .haltPin(haltPin),
      .pinOut(pinOut), .pinOe_n(pinOe_n), .pad(pad));

   function automatic logic [CH-1:0] exp_pad(logic f, logic [CH-1:0] en, logic [CH-1:0] lv,
      logic [CH-1:0] w);
      for (int i = 0; i < CH; i++)
         exp_pad[i] = (f && !en[i]) ? 1'bz : (f ? lv[i] : w[i]);
   endfunction

   // Status while halted: state, 0, fault, halt seen, flag
   function automatic logic [5:0] exp_stat(input int m);
      exp_stat = {(m[1] ? 2'h3 : (m[0] ? 2'h1 : 2'h2)), 1'b0, m[1], 1'b1, m[1]};
   endfunction

   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input pdf_pkg::pdf_addr_t a, input pdf_pkg::pdf_word_t d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge core_clk);
      regWrStrobe <= 1'b0;
   endtask

   task automatic rd(input pdf_pkg::pdf_addr_t a, output pdf_pkg::pdf_word_t d);
      @(posedge core_clk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge core_clk);
      regRdStrobe <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic chk_rd(input pdf_pkg::pdf_addr_t a, input pdf_pkg::pdf_word_t e, input string nm);
      pdf_pkg::pdf_word_t d;
      rd(a, d);
      `CHK(nm, e, d)
      @(posedge core_clk);
      #1;
      `CHK("read idle", 32'h0000_0000, regRdData)
   endtask

   task automatic chk_pins(input logic f);
      `CHK("pinOe_n", f ? ~drv[CH-1:0] : {CH{1'b0}}, pinOe_n)
      `CHK("pad", exp_pad(f, drv[CH-1:0], drv[CH+7:8], waveIn), pad)
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      finish_test();
   end

   initial
   begin
      tick(20);
      reset_n <= 1'b1;
      tick(1);
      chk_rd(`PDF_OFS_DBG, 32'h0000_0000, "dbg reset");
      chk_rd(`PDF_OFS_EVT, 32'h0000_0000, "evt reset");
      chk_rd(8'h04, 32'h0000_0000, "unmapped");
      // Timer still disabled here, so debug bits may be changed
      wr(`PDF_OFS_DBG, 32'h0000_00FF);
      chk_rd(`PDF_OFS_DBG, 32'h0000_0005, "dbg bits");
      wr(`PDF_OFS_EVT, 32'hA5A5_0F0F);
      chk_rd(`PDF_OFS_EVT, 32'hA5A5_0F0F, "evt rw");
      wr(`PDF_OFS_CTRL, 32'h0000_0001);
      chk_rd(`PDF_OFS_DBG, 32'h0000_0005, "dbg after swrst");
      chk_rd(`PDF_OFS_EVT, 32'h0000_0000, "evt after swrst");
      // Fault override from the other fault source, random enables and levels
      repeat (8)
      begin
         drv = $random(seed);
         wr(`PDF_OFS_DRV, drv);
         @(posedge core_clk);
         waveIn <= CH'($random(seed));
         nrFaultIn <= 1'b1;
         tick(2);
         chk_pins(1'b1);
         nrFaultIn <= 1'b0;
         tick(2);
         chk_pins(1'b0);
      end
      // Every run-bit and fault-enable combination under a debug halt
      for (int m = 0; m < 4; m++)
      begin
         wr(`PDF_OFS_CTRL, 32'h0000_0000);
         wr(`PDF_OFS_DBG, {29'h0, m[1], 1'b0, m[0]});
         wr(`PDF_OFS_STAT, 32'h0000_0001);
         drv = $random(seed);
         wr(`PDF_OFS_DRV, drv);
         wr(`PDF_OFS_CTRL, 32'h0000_0002);
         waveIn <= CH'($random(seed));
         tick(1);
         `CHK("count running", 1'b1, countEnable)
         haltReq <= 1'b1;
         tick(1);
         `CHK("count before sync", 1'b1, countEnable)
         `CHK("fault before sync", 1'b0, faultActive)
         tick(2);
         `CHK("count halted", m[0], countEnable)
         `CHK("fault halted", m[1], faultActive)
         chk_pins(m[1]);
         rd(`PDF_OFS_STAT, got);
         `CHK("debug flag", m[1], got[`PDF_STAT_DBGFLAG])
         `CHK("status halted", exp_stat(m), got[5:0])
         @(posedge core_clk);
         haltReq <= 1'b0;
         tick(4);
         `CHK("fault released", 1'b0, faultActive)
         `CHK("count resumed", 1'b1, countEnable)
         chk_rd(`PDF_OFS_STAT, 32'h0000_0010 | m[1], "flag sticky");
         wr(`PDF_OFS_STAT, 32'h0000_0001);
         chk_rd(`PDF_OFS_STAT, 32'h0000_0010, "flag cleared");
      end
      // Clock enable low: a write in that window must not land
      @(posedge core_clk);
      clkEn <= 1'b0;
      wr(`PDF_OFS_DBG, 32'h0000_0000);
      clkEn <= 1'b1;
      chk_rd(`PDF_OFS_DBG, 32'h0000_0005, "dbg frozen");
      // Hard reset in mid-run clears what software reset keeps
      @(posedge core_clk);
      reset_n <= 1'b0;
      tick(1);
      `CHK("oe in reset", {CH{1'b1}}, pinOe_n)
      `CHK("count in reset", 1'b0, countEnable)
      @(posedge core_clk);
      reset_n <= 1'b1;
      tick(1);
      chk_pins(1'b0);
      chk_rd(`PDF_OFS_DBG, 32'h0000_0000, "dbg hard reset");
      chk_rd(`PDF_OFS_STAT, 32'h0000_0000, "stat hard reset");
      finish_test();
   end
endmodule
